// ===== verilog/freq_elements.sv
// Six over/underfrequency elements with a shared undervoltage block
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module freq_elements
#(
  parameter int unsigned NUM_ELEM = freq_elem_pkg::ELEM_COUNT,
  parameter int unsigned QTR_60   = freq_elem_pkg::QTR_CYC_60,
  parameter int unsigned QTR_50   = freq_elem_pkg::QTR_CYC_50,
  // Clock rate times 100; frequency in centihertz is this over the period
  parameter logic [freq_elem_pkg::PROD_W-1:0] FREQ_NUM =
    freq_elem_pkg::FREQ_SCALE
)
(
  input  wire logic                             clock,
  input  wire logic                             reset_n,
  input  wire logic [freq_elem_pkg::ADDR_W-1:0] addr,
  input  wire logic [freq_elem_pkg::DATA_W-1:0] wdata,
  input  wire logic                             wr_en,
  input  wire logic                             rd_en,
  output logic      [freq_elem_pkg::DATA_W-1:0] rdata,
  input  wire logic                             phase_a_neutral_input,
  input  wire logic [freq_elem_pkg::VOLT_W-1:0] volt_a,
  input  wire logic [freq_elem_pkg::VOLT_W-1:0] volt_b,
  input  wire logic [freq_elem_pkg::VOLT_W-1:0] volt_c,
  output logic      [NUM_ELEM-1:0]              freq_element_instant_out,
  output logic      [NUM_ELEM-1:0]              freq_element_delayed_out,
  output logic                                  freq_undervoltage_block_bit,
  output logic                                  irq
);
  import freq_elem_pkg::*;

  initial
  begin
    if (NUM_ELEM < 1 || NUM_ELEM > 6)
      $error("NUM_ELEM must be 1 to 6");
    if (QTR_60 < 1 || QTR_50 < 1 || QTR_50 >= (1 << DIV_W) ||
        QTR_60 >= (1 << DIV_W))
      $error("quarter-cycle counts out of range");
    if (FREQ_NUM == '0)
      $error("frequency scale must not be zero");
  end

  // Settings
  logic                 nominal_frequency_setting_ff;
  logic                 nominal_voltage_off_ff;
  logic                 voltage_connection_type_ff;
  logic [CNT_W-1:0]     freq_element_count_enable_ff;
  logic [VOLT_W-1:0]    freq_undervoltage_block_pickup_ff;
  logic [PICK_W-1:0]    pickup_ff [NUM_ELEM];
  logic [DLY_W-1:0]     delay_ff  [NUM_ELEM];

  // Measurement and element state
  logic                 sync1_ff;
  logic                 sync2_ff;
  logic                 sign_ff;
  logic [PER_W-1:0]     per_cnt_ff;
  logic [PER_W-1:0]     period_ff;
  logic                 valid_ff;
  logic [DIV_W-1:0]     qdiv_ff;
  logic                 qtick_ff;
  logic                 block_ff;
  logic [NUM_ELEM-1:0]  inst_ff;
  logic [NUM_ELEM-1:0]  dly_ff;
  logic [DLY_W-1:0]     tmr_ff [NUM_ELEM];
  logic [IRQ_W-1:0]     irq_st_ff;
  logic [IRQ_W-1:0]     irq_en_ff;
  logic [DATA_W-1:0]    rdata_ff;

  logic                 rise;
  logic                 any_on;
  logic                 nxt_block;
  logic [PICK_W-1:0]    nominal;
  logic [NUM_ELEM-1:0]  elem_on;
  logic [NUM_ELEM-1:0]  over;
  logic [NUM_ELEM-1:0]  above;
  logic [NUM_ELEM-1:0]  nxt_inst;
  logic [NUM_ELEM-1:0]  nxt_dly;
  logic [IRQ_W-1:0]     irq_set;
  logic [IRQ_W-1:0]     irq_clr;
  logic [DATA_W-1:0]    nxt_rdata;

  // Control and block pickup registers
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      nominal_frequency_setting_ff      <= 1'b1;
      nominal_voltage_off_ff            <= 1'b0;
      voltage_connection_type_ff        <= 1'b0;
      freq_element_count_enable_ff      <= '0;
      freq_undervoltage_block_pickup_ff <= UVP_RST;
    end
    else if (wr_en && addr == REG_CTRL)
    begin
      nominal_frequency_setting_ff <= wdata[CTRL_NOM60];
      nominal_voltage_off_ff       <= wdata[CTRL_VOFF];
      voltage_connection_type_ff   <= wdata[CTRL_DELTA];
      freq_element_count_enable_ff <= wdata[CTRL_CNT +: CNT_W];
    end
    else if (wr_en && addr == REG_UV_PICK)
      freq_undervoltage_block_pickup_ff <= wdata[VOLT_W-1:0];
  end

  // Phase A sign passes two flops before the edge detector
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sign_ff  <= 1'b0;
    end
    else
    begin
      sync1_ff <= phase_a_neutral_input;
      sync2_ff <= sync1_ff;
      sign_ff  <= sync2_ff;
    end
  end

  assign rise = sync2_ff && !sign_ff;

  // Period between rising zero crossings; saturates on a dead input
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      per_cnt_ff <= '0;
      period_ff  <= '1;
      valid_ff   <= 1'b0;
    end
    else if (rise)
    begin
      per_cnt_ff <= PER_W'(1);
      period_ff  <= per_cnt_ff;
      valid_ff   <= valid_ff || per_cnt_ff != '0;
    end
    else if (per_cnt_ff != '0 && per_cnt_ff != '1)
      per_cnt_ff <= per_cnt_ff + PER_W'(1);
    else if (per_cnt_ff == '1)
      period_ff  <= '1;
    else
      per_cnt_ff <= per_cnt_ff;
  end

  // Quarter-cycle enable follows the nominal setting
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      qdiv_ff  <= '0;
      qtick_ff <= 1'b0;
    end
    // At or past the end, so a switch to the shorter count cannot stall
    else if (qdiv_ff >= DIV_W'((nominal_frequency_setting_ff ?
                                QTR_60 : QTR_50) - 1))
    begin
      qdiv_ff  <= '0;
      qtick_ff <= 1'b1;
    end
    else
    begin
      qdiv_ff  <= qdiv_ff + DIV_W'(1);
      qtick_ff <= 1'b0;
    end
  end

  // Shared undervoltage block
  assign nominal = nominal_frequency_setting_ff ? NOM60_CHZ
                                                : NOM50_CHZ;
  assign any_on  = freq_element_count_enable_ff != '0;

  always_comb
  begin
    if (nominal_voltage_off_ff)
      nxt_block = volt_a < freq_undervoltage_block_pickup_ff;
    else
      nxt_block = volt_a < freq_undervoltage_block_pickup_ff ||
                  volt_b < freq_undervoltage_block_pickup_ff ||
                  volt_c < freq_undervoltage_block_pickup_ff;
    nxt_block = nxt_block && any_on;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      block_ff <= 1'b0;
    else
      block_ff <= nxt_block;
  end

  // Per-element settings, comparison and delay timer
  for (genvar i = 0; i < NUM_ELEM; i++)
  begin : g_elem
    assign elem_on[i] = CNT_W'(i) < freq_element_count_enable_ff;
    assign over[i]    = pickup_ff[i] >= nominal;
    // Cross-multiplied so no divider is needed
    assign above[i]   = PROD_W'(pickup_ff[i]) * PROD_W'(period_ff)
                        < FREQ_NUM;
    assign nxt_inst[i] = elem_on[i] && valid_ff && !nxt_block &&
                         (over[i] ? above[i]
                                  : !above[i]);
    assign nxt_dly[i]  = nxt_inst[i] && tmr_ff[i] >= delay_ff[i];

    always_ff @(posedge clock)
    begin
      if (!reset_n)
      begin
        pickup_ff[i] <= PICK_RST;
        delay_ff[i]  <= DLY_MIN;
      end
      else if (wr_en && addr == REG_PICK0 + ADDR_W'(4 * i))
        pickup_ff[i] <= wdata[PICK_W-1:0];
      else if (wr_en && addr == REG_DLY0 + ADDR_W'(4 * i))
      begin
        // Out-of-range delays clamp to the legal span
        if (wdata[DLY_W-1:0] < DLY_MIN)
          delay_ff[i] <= DLY_MIN;
        else if (wdata[DLY_W-1:0] > DLY_MAX)
          delay_ff[i] <= DLY_MAX;
        else
          delay_ff[i] <= wdata[DLY_W-1:0];
      end
    end

    always_ff @(posedge clock)
    begin
      if (!reset_n)
        tmr_ff[i] <= '0;
      else if (!nxt_inst[i])
        tmr_ff[i] <= '0;
      else if (qtick_ff && tmr_ff[i] != '1)
        tmr_ff[i] <= tmr_ff[i] + DLY_W'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      inst_ff <= '0;
      dly_ff  <= '0;
    end
    else
    begin
      inst_ff <= nxt_inst;
      dly_ff  <= nxt_dly;
    end
  end

  assign freq_element_instant_out    = inst_ff;
  assign freq_element_delayed_out    = dly_ff;
  assign freq_undervoltage_block_bit = block_ff;

  // Sticky events; a set in the clear cycle wins
  always_comb
  begin
    irq_set                = '0;
    irq_set[NUM_ELEM-1:0]  = nxt_dly & ~dly_ff;
    irq_set[IRQ_BLK]       = nxt_block && !block_ff;
  end
  assign irq_clr = (wr_en && addr == REG_IRQ_CLR) ?
                   wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      irq_st_ff <= '0;
      irq_en_ff <= '0;
    end
    else
    begin
      irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_set;
      if (wr_en && addr == REG_IRQ_EN)
        irq_en_ff <= wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_st_ff & irq_en_ff);

  // Read path, data one cycle after the strobe
  always_comb
  begin
    nxt_rdata = '0;
    if (addr == REG_CTRL)
    begin
      nxt_rdata[CTRL_NOM60] = nominal_frequency_setting_ff;
      nxt_rdata[CTRL_VOFF]  = nominal_voltage_off_ff;
      nxt_rdata[CTRL_DELTA] = voltage_connection_type_ff;
      nxt_rdata[CTRL_CNT +: CNT_W] = freq_element_count_enable_ff;
    end
    else if (addr == REG_UV_PICK)
      nxt_rdata[VOLT_W-1:0] = freq_undervoltage_block_pickup_ff;
    else if (addr == REG_STATE)
    begin
      nxt_rdata[ST_INST +: NUM_ELEM] = inst_ff;
      nxt_rdata[ST_DLY +: NUM_ELEM]  = dly_ff;
      nxt_rdata[ST_BLOCK]            = block_ff;
      nxt_rdata[ST_VALID]            = valid_ff;
    end
    else if (addr == REG_PERIOD)
      nxt_rdata[PER_W-1:0] = period_ff;
    else if (addr == REG_IRQ_ST)
      nxt_rdata[IRQ_W-1:0] = irq_st_ff;
    else if (addr == REG_IRQ_EN)
      nxt_rdata[IRQ_W-1:0] = irq_en_ff;
    else
    begin
      for (int k = 0; k < NUM_ELEM; k++)
      begin
        if (addr == REG_PICK0 + ADDR_W'(4 * k))
          nxt_rdata[PICK_W-1:0] = pickup_ff[k];
        if (addr == REG_DLY0 + ADDR_W'(4 * k))
          nxt_rdata[DLY_W-1:0] = delay_ff[k];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      rdata_ff <= '0;
    else if (rd_en)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= '0;
  end

  assign rdata = rdata_ff;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  block_gates_out_a: assert property (
    block_ff |-> inst_ff == '0 && dly_ff == '0)
    else $error("output high while blocked");

  uv_wye_block_a: assert property (
    any_on && !nominal_voltage_off_ff &&
    volt_b < freq_undervoltage_block_pickup_ff |=> block_ff)
    else $error("phase B sag did not block");

  uv_off_phase_a: assert property (
    any_on && nominal_voltage_off_ff &&
    volt_a >= freq_undervoltage_block_pickup_ff |=> !block_ff)
    else $error("other phases blocked with voltage setting off");

  block_needs_enable_a: assert property (
    !any_on |=> !block_ff)
    else $error("block bit with no element enabled");

  count_none_a: assert property (
    freq_element_count_enable_ff == '0 |=> inst_ff == '0)
    else $error("element active with count zero");

  delay_range_a: assert property (
    delay_ff[0] >= DLY_MIN && delay_ff[0] <= DLY_MAX)
    else $error("delay outside legal span");

  for (genvar j = 0; j < NUM_ELEM; j++)
  begin : g_chk
    over_sense_a: assert property (
      over[j] && !above[j] |=> !inst_ff[j])
      else $error("overfrequency output at or below pickup");

    under_sense_a: assert property (
      !over[j] && above[j] |=> !inst_ff[j])
      else $error("underfrequency output above pickup");

    delayed_after_inst_a: assert property (
      $rose(dly_ff[j]) |-> $past(inst_ff[j]) &&
      $past(tmr_ff[j]) >= $past(delay_ff[j]))
      else $error("delayed output rose too early");

    timer_restart_a: assert property (
      !inst_ff[j] |-> tmr_ff[j] == '0)
      else $error("timer not restarted on dropout");
  end

  mode_select_a: assert property (
    elem_on[0] && valid_ff && !nxt_block && above[0] &&
    pickup_ff[0] >= (nominal_frequency_setting_ff ? NOM60_CHZ : NOM50_CHZ)
    |=> inst_ff[0])
    else $error("over/under mode wrong");

  irq_sticky_a: assert property (
    $rose(block_ff) |-> irq_st_ff[IRQ_BLK])
    else $error("block event not latched");

  over_trip_c: cover property (over[0] && $rose(dly_ff[0]));
  under_trip_c: cover property (!over[1] && $rose(dly_ff[1]));
  block_c: cover property ($rose(block_ff) && $past(inst_ff != '0));
  dropout_c: cover property ($fell(inst_ff[0]) && !dly_ff[0]);

endmodule

// ===== shared/freq_elem_pkg.sv
// Constants shared by the frequency element block
package freq_elem_pkg;

  // Clock and element set
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned ELEM_COUNT = 6;

  // Quarter power-system cycle, derived from the clock rate
  localparam int unsigned NOM_HZ_60  = 60;
  localparam int unsigned NOM_HZ_50  = 50;
  localparam int unsigned QTR_CYC_60 = CLK_HZ / (4 * NOM_HZ_60);
  localparam int unsigned QTR_CYC_50 = CLK_HZ / (4 * NOM_HZ_50);
  localparam int unsigned DIV_W      = 18;

  // Widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned VOLT_W = 16;
  localparam int unsigned PICK_W = 13;
  localparam int unsigned DLY_W  = 16;
  localparam int unsigned PER_W  = 21;
  localparam int unsigned CNT_W  = 3;
  localparam int unsigned PROD_W = PICK_W + PER_W;

  // Frequency in centihertz is CLK_HZ * 100 / period
  localparam logic [PROD_W-1:0] FREQ_SCALE =
    PROD_W'(64'(CLK_HZ) * 64'd100);
  localparam logic [PICK_W-1:0] NOM60_CHZ = 13'h1770;
  localparam logic [PICK_W-1:0] NOM50_CHZ = 13'h1388;

  // Delay in quarter cycles: 2.00 to 16000.00 cycles
  localparam logic [DLY_W-1:0] DLY_MIN = 16'h0008;
  localparam logic [DLY_W-1:0] DLY_MAX = 16'hFA00;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_UV_PICK = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATE   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PERIOD  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_IRQ_ST  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h14;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_PICK0   = 8'h20;
  localparam logic [ADDR_W-1:0] REG_DLY0    = 8'h40;

  // Control field positions
  localparam int unsigned CTRL_NOM60 = 0;
  localparam int unsigned CTRL_VOFF  = 1;
  localparam int unsigned CTRL_DELTA = 2;
  localparam int unsigned CTRL_CNT   = 4;

  // State and interrupt register field positions
  localparam int unsigned ST_INST  = 0;
  localparam int unsigned ST_DLY   = 8;
  localparam int unsigned ST_BLOCK = 16;
  localparam int unsigned ST_VALID = 17;
  localparam int unsigned IRQ_BLK  = 6;
  localparam int unsigned IRQ_W    = 7;

  // Reset values
  localparam logic [PICK_W-1:0] PICK_RST = 13'h1770;
  localparam logic [VOLT_W-1:0] UVP_RST  = 16'h0000;

endpackage

// ===== verif/over_under_frequency_elements_test.sv
// Self-checking bench for the six frequency elements block
`timescale 1ns/1ps
module over_under_frequency_elements_test;
  import freq_elem_pkg::*;
  // Short quarter ticks keep delay runs to a few hundred clocks
  localparam int Q60 = 4;
  localparam int Q50 = 5;
  localparam logic [15:0] HI = 16'h2000;
  localparam logic [15:0] LO = 16'h0FFF;
  localparam logic [15:0] EQ = 16'h1000;
  // Scale so a 400-clock period reads 61.00 Hz and 488 reads 50.00 Hz
  localparam logic [33:0] SCALE = 34'h0253B40;
  typedef struct {
    logic [7:0]  ctrl;
    logic [12:0] pick;
    logic [15:0] va;
    logic [15:0] vb;
    logic [15:0] vc;
    logic        blk;
    logic        ins;
  } row_t;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rdata;
  logic        pin = 1'b0;
  logic [15:0] volt_a = HI;
  logic [15:0] volt_b = HI;
  logic [15:0] volt_c = HI;
  logic [5:0]  inst;
  logic [5:0]  dly;
  logic        blk;
  logic        irq;
  logic        wave_on = 1'b0;
  int          half = 0;
  int          hp = 199;
  int          miscompares = 0;
  int          compares = 0;
  int          n;
  int          q;
  logic [31:0] rd_v;
  row_t        rows [13];

  freq_elements #(
    .NUM_ELEM (6),
    .QTR_60   (Q60),
    .QTR_50   (Q50),
    .FREQ_NUM (SCALE)
  ) uut (
    .clock                       (clock),
    .reset_n                     (reset_n),
    .addr                        (addr),
    .wdata                       (wdata),
    .wr_en                       (wr_en),
    .rd_en                       (rd_en),
    .rdata                       (rdata),
    .phase_a_neutral_input       (pin),
    .volt_a                      (volt_a),
    .volt_b                      (volt_b),
    .volt_c                      (volt_c),
    .freq_element_instant_out    (inst),
    .freq_element_delayed_out    (dly),
    .freq_undervoltage_block_bit (blk),
    .irq                         (irq)
  );

  always #12.5 clock = ~clock;

  // Phase A sign, 2 * (hp + 1) clocks between rising crossings
  always @(posedge clock)
  begin
    if (wave_on)
    begin
      if (half >= hp)
      begin
        half <= 0;
        pin  <= ~pin;
      end
      else
        half <= half + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rd_v);
    chk(rd_v, e);
  endtask

  task automatic vset(input logic [15:0] a, input logic [15:0] b,
                      input logic [15:0] c);
    @(posedge clock);
    volt_a <= a;
    volt_b <= b;
    volt_c <= c;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // Clocks from instant rise to delayed rise of element 0
  task automatic time_dly(output int m);
    vset(HI, HI, HI);
    m = 0;
    while (inst[0] !== 1'b1 && m < 50)
    begin
      cyc(1);
      m++;
    end
    m = 0;
    while (dly[0] !== 1'b1 && m < 300)
    begin
      cyc(1);
      m++;
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d, miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Whole run is near 3100 clocks; allow 20000, over six times that
  initial
  begin
    #(20000 * 25);
    miscompares++;
    end_of_test;
  end

  initial
  begin
    rows = '{
      '{8'h11, 13'h1770, HI, HI, HI, 1'b0, 1'b1},
      '{8'h11, 13'h176F, HI, HI, HI, 1'b0, 1'b0},
      '{8'h10, 13'h157C, HI, HI, HI, 1'b0, 1'b1},
      '{8'h11, 13'h157C, HI, HI, HI, 1'b0, 1'b0},
      '{8'h11, 13'h17D4, HI, HI, HI, 1'b0, 1'b0},
      '{8'h11, 13'h17D3, HI, HI, HI, 1'b0, 1'b1},
      '{8'h11, 13'h1770, LO, HI, HI, 1'b1, 1'b0},
      '{8'h11, 13'h1770, HI, LO, HI, 1'b1, 1'b0},
      '{8'h15, 13'h1770, HI, HI, LO, 1'b1, 1'b0},
      '{8'h13, 13'h1770, HI, LO, LO, 1'b0, 1'b1},
      '{8'h13, 13'h1770, LO, HI, HI, 1'b1, 1'b0},
      '{8'h11, 13'h1770, EQ, EQ, EQ, 1'b0, 1'b1},
      '{8'h01, 13'h1770, LO, LO, LO, 1'b0, 1'b0}
    };
    repeat (2) @(posedge clock);
    #1;
    chk({18'h0, irq, blk, dly, inst}, 32'h0);
    chk(rdata, 32'h0);
    @(posedge clock);
    reset_n <= 1'b1;
    rchk(REG_CTRL, 32'h1);
    rchk(REG_UV_PICK, 32'h0);
    rchk(REG_PERIOD, 32'h001FFFFF);
    rchk(REG_IRQ_EN, 32'h0);
    rchk(REG_IRQ_CLR, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      rchk(REG_PICK0 + 8'(4 * i), 32'h1770);
      rchk(REG_DLY0 + 8'(4 * i), 32'h8);
    end
    // Read-only and unmapped places must ignore writes
    wr(REG_STATE, 32'hFFFFFFFF);
    wr(REG_IRQ_ST, 32'hFFFFFFFF);
    wr(8'h1C, 32'hFFFFFFFF);
    rchk(REG_STATE, 32'h0);
    rchk(REG_IRQ_ST, 32'h0);
    rchk(8'h1C, 32'h0);
    $display("reset and register test done");

    @(posedge clock);
    wave_on <= 1'b1;
    cyc(1000);
    rchk(REG_PERIOD, 32'h00000190);
    rchk(REG_STATE, 32'h00020000);
    $display("measurement test done");

    wr(REG_UV_PICK, 32'h1000);
    foreach (rows[i])
    begin
      wr(REG_CTRL, 32'(rows[i].ctrl));
      wr(REG_PICK0, 32'(rows[i].pick));
      vset(rows[i].va, rows[i].vb, rows[i].vc);
      cyc(5);
      chk(32'(blk), 32'(rows[i].blk));
      chk(32'(inst[0]), 32'(rows[i].ins));
      rd(REG_STATE, rd_v);
      chk(32'(rd_v[16]), 32'(rows[i].blk));
    end
    $display("table test done");

    vset(HI, HI, HI);
    wr(REG_CTRL, 32'h1);
    cyc(5);
    wr(REG_IRQ_CLR, 32'h7F);
    rchk(REG_IRQ_ST, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      wr(REG_CTRL, 32'(c * 16 + 1));
      cyc(4);
      chk(32'(inst), (32'h1 << (c > 6 ? 6 : c)) - 32'h1);
    end
    cyc(60);
    chk(32'(dly), 32'h3F);
    rchk(REG_IRQ_ST, 32'h3F);
    chk(32'(irq), 32'h0);
    wr(REG_IRQ_EN, 32'h3F);
    cyc(1);
    chk(32'(irq), 32'h1);
    wr(REG_IRQ_CLR, 32'h01);
    rchk(REG_IRQ_ST, 32'h3E);
    wr(REG_IRQ_CLR, 32'h3E);
    rchk(REG_IRQ_ST, 32'h0);
    chk(32'(irq), 32'h0);
    wr(REG_IRQ_EN, 32'h40);
    vset(LO, HI, HI);
    cyc(3);
    chk(32'(irq), 32'h1);
    chk(32'({inst, dly}), 32'h0);
    rchk(REG_IRQ_ST, 32'h40);
    // Status is set by the rise only, so a standing block clears
    wr(REG_IRQ_CLR, 32'h40);
    cyc(1);
    chk(32'(irq), 32'h0);
    rchk(REG_IRQ_EN, 32'h40);
    $display("count and interrupt test done");

    wr(REG_CTRL, 32'h1);
    wr(REG_DLY0, 32'h14);
    for (int k = 0; k < 2; k++)
    begin
      q = k ? Q50 : Q60;
      wr(REG_CTRL, k ? 32'h10 : 32'h11);
      vset(LO, HI, HI);
      cyc(4);
      chk(32'({inst[0], dly[0]}), 32'h0);
      time_dly(n);
      chk(32'(n >= 19 * q - 4 && n <= 21 * q + 4), 32'h1);
      vset(LO, HI, HI);
      cyc(3);
      vset(HI, HI, HI);
      cyc(45);
      // Drop out through an under pickup below the present frequency
      wr(REG_PICK0, k ? 32'h1387 : 32'h176F);
      wr(REG_PICK0, 32'h1770);
      time_dly(n);
      chk(32'(n >= 19 * q - 4 && n <= 21 * q + 4), 32'h1);
    end
    wr(REG_DLY0 + 8'h04, 32'h3);
    rchk(REG_DLY0 + 8'h04, 32'h8);
    wr(REG_DLY0 + 8'h08, 32'hFFFF);
    rchk(REG_DLY0 + 8'h08, 32'hFA00);
    wr(REG_DLY0 + 8'h0C, 32'h1234);
    rchk(REG_DLY0 + 8'h0C, 32'h1234);
    $display("delay test done");

    hp <= 243;
    cyc(1100);
    rchk(REG_PERIOD, 32'h000001E8);
    wr(REG_CTRL, 32'h11);
    wr(REG_PICK0, 32'h1388);
    cyc(4);
    chk(32'(inst[0]), 32'h1);
    cyc(100);
    chk(32'(dly[0]), 32'h1);
    wr(REG_PICK0, 32'h1387);
    cyc(4);
    chk(32'({inst[0], dly[0]}), 32'h0);
    wr(REG_CTRL, 32'h10);
    wr(REG_PICK0, 32'h1388);
    cyc(4);
    chk(32'(inst[0]), 32'h0);
    $display("underfrequency test done");
    end_of_test;
  end
endmodule
